// file: rtl/csr_call_stack.sv
// Circular hardware return-address stack with registered top entry
`timescale 1ns/1ps
module csr_call_stack #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 12
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] pushData,
  output logic [WIDTH-1:0] top
);

  localparam int PTR_W = $clog2(DEPTH);

  typedef struct packed {
    logic [PTR_W-1:0] ptr;
    logic [WIDTH-1:0] top;
  } csr_stack_state_t;

  csr_stack_state_t s_q;
  csr_stack_state_t s_d;
  logic [WIDTH-1:0] mem [DEPTH];

  // Overflow wraps and overwrites the oldest entry, as small cores do
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.ptr = s_q.ptr + PTR_W'(1);
      s_d.top = pushData;
    end else if (pop) begin
      s_d.ptr = s_q.ptr - PTR_W'(1);
      s_d.top = mem[s_q.ptr - PTR_W'(2)];
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[s_q.ptr] <= pushData;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign top = s_q.top;

endmodule : csr_call_stack

// file: rtl/csr_core_regs.sv
// Core special registers and program counter sequencing
`timescale 1ns/1ps
module csr_core_regs #(
  parameter int STACK_DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input csr_pkg::csr_op_t op,
  input wire logic [csr_pkg::JMP_W-1:0] operand,
  input wire logic [7:0] acc,
  input csr_pkg::csr_alu_flags_t aluFlags,
  input csr_pkg::csr_reg_req_t regReq,
  input wire logic instrTick,
  input wire logic slowClkPin,
  input wire logic timerUseInstrClk,
  input wire logic wdtTimeout,
  input wire logic pinResetWake,
  input wire logic wakeEvent,
  output logic [7:0] regRdData,
  output csr_pkg::csr_ram_req_t ramReq,
  output logic [csr_pkg::PC_W-1:0] fetchAddr,
  output logic [7:0] statusOut,
  output logic ctlPage,
  output logic [1:0] regPage,
  output logic asleep,
  output logic [7:0] accRestore,
  output logic accRestoreValid
);

  csr_pkg::csr_state_t s_q;
  csr_pkg::csr_state_t s_d;
  logic [csr_pkg::PC_W-1:0] stackTop;
  logic [csr_pkg::PC_W-1:0] pushData;
  logic [csr_pkg::PC_W-1:0] nextPc;
  logic [1:0] progPageBits;
  logic [csr_pkg::ADDR_W-1:0] effAddr;
  logic push;
  logic pop;
  logic timerWr;
  logic [7:0] timerCount;

  // Indirect location has no storage; it stands for the address held in select
  function automatic logic [csr_pkg::ADDR_W-1:0] resolveAddr(
    input logic [csr_pkg::ADDR_W-1:0] addr,
    input logic [7:0] ramSel
  );
    if (addr == csr_pkg::OFF_INDIRECT) begin
      resolveAddr = ramSel[csr_pkg::ADDR_W-1:0];
    end else begin
      resolveAddr = addr;
    end
  endfunction : resolveAddr

  // Special registers below 0x05 stay visible on every page so status is never lost
  function automatic logic isSpecial(
    input logic [csr_pkg::ADDR_W-1:0] addr,
    input logic [csr_pkg::ADDR_W-1:0] target,
    input logic [1:0] page
  );
    if (target == csr_pkg::OFF_PROGPAGE) begin
      isSpecial = (addr == target) && (page == 2'b00);
    end else begin
      isSpecial = (addr == target);
    end
  endfunction : isSpecial

  assign effAddr = resolveAddr(regReq.addr, s_q.ramSel);
  // Only the two page bits reach the address; bits two and three are software's duty
  assign progPageBits = s_q.progPage[1:0];
  assign nextPc = s_q.pc + 12'h001;
  assign timerWr = regReq.wr && isSpecial(effAddr, csr_pkg::OFF_TIMER, regPage);

  always_comb begin
    ramReq.sel = (regReq.rd || regReq.wr) && (effAddr >= csr_pkg::GLOBAL_BASE);
    ramReq.banked = effAddr >= csr_pkg::BANKED_BASE;
    ramReq.bank = s_q.ramSel[csr_pkg::RS_BANK_LO +: 2];
    ramReq.addr = effAddr;
  end

  csr_free_timer u_timer (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .slowClkPin(slowClkPin),
    .useInstrClk(timerUseInstrClk),
    .instrTick(instrTick),
    .wrEn(timerWr),
    .wrData(regReq.wdata),
    .count(timerCount)
  );

  csr_call_stack #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(csr_pkg::PC_W)
  ) u_stack (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .push(push),
    .pop(pop),
    .pushData(pushData),
    .top(stackTop)
  );

  always_comb begin
    s_d = s_q;
    s_d.accRestoreValid = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    pushData = nextPc;
    case (op)
      csr_pkg::OP_NEXT: begin
        s_d.pc = nextPc;
      end
      csr_pkg::OP_JMP: begin
        s_d.pc = {progPageBits, operand};
      end
      csr_pkg::OP_CALL: begin
        push = 1'b1;
        s_d.pc = {progPageBits, operand};
      end
      csr_pkg::OP_RET, csr_pkg::OP_RETURN_WITH_LITERAL: begin
        pop = 1'b1;
        s_d.pc = stackTop;
      end
      csr_pkg::OP_RETURN_FROM_INTERRUPT: begin
        pop = 1'b1;
        s_d.pc = stackTop;
        // Flags that record wake cause stay live across the restore
        s_d.status = (s_q.shStatus & ~csr_pkg::STATUS_RO_MASK) |
                     (s_q.status & csr_pkg::STATUS_RO_MASK);
        s_d.progPage = s_q.shPage;
        s_d.accRestore = s_q.shAcc;
        s_d.accRestoreValid = 1'b1;
      end
      csr_pkg::OP_MOVPC: begin
        s_d.pc = {progPageBits, 2'b00, acc};
      end
      csr_pkg::OP_ADDPC: begin
        s_d.pc = {progPageBits, 2'b00, s_q.pc[7:0] + acc};
      end
      csr_pkg::OP_TBL: begin
        s_d.pc = {s_q.pc[11:8], s_q.pc[7:0] + acc};
      end
      csr_pkg::OP_INT: begin
        // The interrupted instruction is resumed, so its own address is saved
        push = 1'b1;
        pushData = s_q.pc;
        s_d.pc = csr_pkg::INT_VECTOR;
        s_d.shAcc = acc;
        s_d.shStatus = s_q.status;
        s_d.shPage = s_q.progPage;
        s_d.progPage = csr_pkg::PROGPAGE_RST;
      end
      csr_pkg::OP_PAGE: begin
        s_d.progPage[1:0] = operand[1:0];
        s_d.pc = nextPc;
      end
      csr_pkg::OP_SLEEP: begin
        s_d.status[csr_pkg::ST_TIMEOUT] = 1'b1;
        s_d.status[csr_pkg::ST_PWRDN] = 1'b0;
        s_d.run = csr_pkg::RUN_ASLEEP;
        s_d.pc = nextPc;
      end
      csr_pkg::OP_WATCHDOG_CLEAR_INSTRUCTION: begin
        s_d.status[csr_pkg::ST_TIMEOUT] = 1'b1;
        s_d.status[csr_pkg::ST_PWRDN] = 1'b1;
        s_d.pc = nextPc;
      end
      default: begin
      end
    endcase

    if (aluFlags.we) begin
      s_d.status[csr_pkg::ST_ZERO:csr_pkg::ST_CARRY] = aluFlags.val;
    end

    // Software writes follow the instruction side effects in the same cycle
    if (regReq.wr) begin
      if (isSpecial(effAddr, csr_pkg::OFF_STATUS, regPage)) begin
        s_d.status = (regReq.wdata & ~csr_pkg::STATUS_RO_MASK) |
                     (s_d.status & csr_pkg::STATUS_RO_MASK);
      end
      if (isSpecial(effAddr, csr_pkg::OFF_RAMSEL, regPage)) begin
        s_d.ramSel = regReq.wdata;
      end
      if (isSpecial(effAddr, csr_pkg::OFF_PROGPAGE, regPage)) begin
        s_d.progPage = regReq.wdata & csr_pkg::PROGPAGE_MASK;
      end
    end

    if (wakeEvent && s_q.run == csr_pkg::RUN_ASLEEP) begin
      s_d.run = csr_pkg::RUN_AWAKE;
    end

    // Pin wake keeps the flags left by sleep, giving the one-zero pair
    if (pinResetWake) begin
      s_d.pc = csr_pkg::RESET_VECTOR;
      s_d.run = csr_pkg::RUN_AWAKE;
      s_d.progPage = csr_pkg::PROGPAGE_RST;
      s_d.status[7:csr_pkg::ST_CTLPAGE] = 3'b000;
    end

    // Watchdog reset wins over ops and pin wake for pc, run state, program page, page selects and time-out flag
    if (wdtTimeout) begin
      s_d.status[csr_pkg::ST_TIMEOUT] = 1'b0;
      if (s_q.run == csr_pkg::RUN_ASLEEP) begin
        s_d.status[csr_pkg::ST_PWRDN] = 1'b0;
      end
      s_d.pc = csr_pkg::RESET_VECTOR;
      s_d.run = csr_pkg::RUN_AWAKE;
      s_d.progPage = csr_pkg::PROGPAGE_RST;
      s_d.status[7:csr_pkg::ST_CTLPAGE] = 3'b000;
    end

    s_d.rdData = 8'h00;
    if (regReq.rd) begin
      if (isSpecial(effAddr, csr_pkg::OFF_TIMER, regPage)) begin
        s_d.rdData = timerCount;
      end else if (isSpecial(effAddr, csr_pkg::OFF_PC, regPage)) begin
        s_d.rdData = s_q.pc[7:0];
      end else if (isSpecial(effAddr, csr_pkg::OFF_STATUS, regPage)) begin
        s_d.rdData = s_q.status;
      end else if (isSpecial(effAddr, csr_pkg::OFF_RAMSEL, regPage)) begin
        s_d.rdData = s_q.ramSel;
      end else if (isSpecial(effAddr, csr_pkg::OFF_PROGPAGE, regPage)) begin
        s_d.rdData = s_q.progPage;
      end else begin
        s_d.rdData = 8'h00;
      end
    end
  end

  // Power-on sets both time-out and power-down flags
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q.pc <= csr_pkg::RESET_VECTOR;
      s_q.status <= csr_pkg::STATUS_RST;
      s_q.ramSel <= csr_pkg::RAMSEL_RST;
      s_q.progPage <= csr_pkg::PROGPAGE_RST;
      s_q.run <= csr_pkg::RUN_AWAKE;
      s_q.shAcc <= 8'h00;
      s_q.shStatus <= 8'h00;
      s_q.shPage <= 8'h00;
      s_q.rdData <= 8'h00;
      s_q.accRestore <= 8'h00;
      s_q.accRestoreValid <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign regRdData = s_q.rdData;
  assign fetchAddr = s_q.pc;
  assign statusOut = s_q.status;
  assign ctlPage = s_q.status[csr_pkg::ST_CTLPAGE];
  assign regPage = s_q.status[csr_pkg::ST_RPAGE_LO +: 2];
  assign asleep = (s_q.run == csr_pkg::RUN_ASLEEP);
  assign accRestore = s_q.accRestore;
  assign accRestoreValid = s_q.accRestoreValid;

endmodule : csr_core_regs

// file: rtl/csr_free_timer.sv
// Free-running timer data register with selectable count source
`timescale 1ns/1ps
module csr_free_timer (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic slowClkPin,
  input wire logic useInstrClk,
  input wire logic instrTick,
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  output logic [7:0] count
);

  csr_pkg::csr_timer_state_t s_q;
  csr_pkg::csr_timer_state_t s_d;
  logic slowEdge;

  // Only the second stage feeds the edge detector
  assign slowEdge = s_q.sync[1] & ~s_q.prev;

  always_comb begin
    s_d = s_q;
    s_d.sync = {s_q.sync[0], slowClkPin};
    s_d.prev = s_q.sync[1];
    if (wrEn) begin
      s_d.cnt = wrData;
    end else if (useInstrClk ? instrTick : slowEdge) begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count = s_q.cnt;

endmodule : csr_free_timer

// file: rtl/csr_pkg.sv
// Shared constants, types and state records for the core special registers
package csr_pkg;

  localparam int PC_W = 12;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int JMP_W = 10;

  // Register offsets
  localparam logic [5:0] OFF_INDIRECT = 6'h00;
  localparam logic [5:0] OFF_TIMER = 6'h01;
  localparam logic [5:0] OFF_PC = 6'h02;
  localparam logic [5:0] OFF_STATUS = 6'h03;
  localparam logic [5:0] OFF_RAMSEL = 6'h04;
  localparam logic [5:0] OFF_PROGPAGE = 6'h05;
  localparam logic [5:0] GLOBAL_BASE = 6'h10;
  localparam logic [5:0] BANKED_BASE = 6'h20;

  // Status and RAM select field positions
  localparam int ST_CARRY = 0;
  localparam int ST_AUX = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_PWRDN = 3;
  localparam int ST_TIMEOUT = 4;
  localparam int ST_CTLPAGE = 5;
  localparam int ST_RPAGE_LO = 6;
  localparam int RS_BANK_LO = 6;

  // Reset values, masks and vectors
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] RAMSEL_RST = 8'h00;
  localparam logic [7:0] PROGPAGE_RST = 8'h00;
  localparam logic [7:0] PROGPAGE_MASK = 8'h0f;
  localparam logic [7:0] STATUS_RO_MASK = 8'h18;
  localparam logic [PC_W-1:0] RESET_VECTOR = 12'h000;
  localparam logic [PC_W-1:0] INT_VECTOR = 12'h008;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_NEXT = 4'h1,
    OP_JMP = 4'h2,
    OP_CALL = 4'h3,
    OP_RET = 4'h4,
    OP_RETURN_WITH_LITERAL = 4'h5,
    OP_RETURN_FROM_INTERRUPT = 4'h6,
    OP_MOVPC = 4'h7,
    OP_ADDPC = 4'h8,
    OP_TBL = 4'h9,
    OP_INT = 4'ha,
    OP_PAGE = 4'hb,
    OP_SLEEP = 4'hc,
    OP_WATCHDOG_CLEAR_INSTRUCTION = 4'hd
  } csr_op_t;

  typedef enum logic [1:0] {
    RUN_AWAKE = 2'b01,
    RUN_ASLEEP = 2'b10
  } csr_run_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } csr_reg_req_t;

  typedef struct packed {
    logic sel;
    logic banked;
    logic [1:0] bank;
    logic [ADDR_W-1:0] addr;
  } csr_ram_req_t;

  typedef struct packed {
    logic we;
    logic [2:0] val;
  } csr_alu_flags_t;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [7:0] status;
    logic [7:0] ramSel;
    logic [7:0] progPage;
    csr_run_t run;
    logic [7:0] shAcc;
    logic [7:0] shStatus;
    logic [7:0] shPage;
    logic [7:0] rdData;
    logic [7:0] accRestore;
    logic accRestoreValid;
  } csr_state_t;

  typedef struct packed {
    logic [1:0] sync;
    logic prev;
    logic [7:0] cnt;
  } csr_timer_state_t;

endpackage : csr_pkg

// file: testbench/csr_core_regs_asserts.sv
// Concurrent checks on the core special register ports
`timescale 1ns/1ps
module csr_core_regs_asserts (
  input wire logic core_clk,
  input wire logic arst_n,
  input csr_pkg::csr_op_t op,
  input wire logic [csr_pkg::JMP_W-1:0] operand,
  input wire logic [7:0] acc,
  input csr_pkg::csr_reg_req_t regReq,
  input wire logic wdtTimeout,
  input wire logic pinResetWake,
  input csr_pkg::csr_ram_req_t ramReq,
  input wire logic [csr_pkg::PC_W-1:0] fetchAddr,
  input wire logic [7:0] statusOut,
  input wire logic ctlPage,
  input wire logic [1:0] regPage,
  input wire logic asleep,
  input wire logic accRestoreValid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic calm;
  // Watchdog and pin wake override any op
  assign calm = !wdtTimeout && !pinResetWake;
  jump_load_a: assert property (calm && op inside {csr_pkg::OP_JMP, csr_pkg::OP_CALL}
    |=> fetchAddr[9:0] == $past(operand)) else $error("jump target not loaded");
  int_vector_a: assert property (calm && op == csr_pkg::OP_INT
    |=> fetchAddr == csr_pkg::INT_VECTOR) else $error("interrupt vector wrong");
  tbl_keep_a: assert property (calm && op == csr_pkg::OP_TBL
    |=> fetchAddr == {$past(fetchAddr[11:8]), $past(fetchAddr[7:0]) + $past(acc)})
    else $error("table read address wrong");
  pc_step_a: assert property (calm && op == csr_pkg::OP_NEXT
    |=> fetchAddr == $past(fetchAddr) + 12'h001) else $error("counter did not step");
  sleep_flags_a: assert property (calm && op == csr_pkg::OP_SLEEP
    |=> {statusOut[4:3], asleep} == 3'h5) else $error("sleep flags wrong");
  wdt_cause_a: assert property (wdtTimeout |=> !statusOut[4] && fetchAddr == 12'h000
    && statusOut[3] == ($past(asleep) ? 1'b0 : $past(statusOut[3])))
    else $error("watchdog flags wrong");
  page_out_a: assert property (ctlPage == statusOut[5] && regPage == statusOut[7:6])
    else $error("page selects differ from status");
  ram_route_a: assert property (regReq.rd && regReq.addr >= csr_pkg::GLOBAL_BASE
    |-> ramReq.sel && ramReq.addr == regReq.addr
    && ramReq.banked == (regReq.addr >= csr_pkg::BANKED_BASE)) else $error("ram route wrong");
  return_from_interrupt_pulse_a: assert property (calm
    |=> accRestoreValid == ($past(op) == csr_pkg::OP_RETURN_FROM_INTERRUPT)) else $error("restore pulse wrong");
  cover property (op == csr_pkg::OP_CALL ##1 op == csr_pkg::OP_RET);
  cover property (wdtTimeout && asleep);
  cover property (accRestoreValid);
endmodule : csr_core_regs_asserts

bind csr_core_regs csr_core_regs_asserts i_chk (.core_clk(core_clk), .arst_n(arst_n),
  .op(op), .operand(operand), .acc(acc), .regReq(regReq), .wdtTimeout(wdtTimeout),
  .pinResetWake(pinResetWake), .ramReq(ramReq), .fetchAddr(fetchAddr),
  .statusOut(statusOut), .ctlPage(ctlPage), .regPage(regPage), .asleep(asleep),
  .accRestoreValid(accRestoreValid));

// file: testbench/csr_core_regs_bench.sv
// Self-checking bench for the core special registers
`timescale 1ns/1ps
module csr_core_regs_bench;
  typedef struct packed {logic [1:0] k; logic [11:0] v;} csr_note_t;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  csr_pkg::csr_op_t op = csr_pkg::OP_NONE;
  logic [9:0] operand = 10'h000;
  logic [7:0] acc = 8'h00;
  csr_pkg::csr_alu_flags_t aluFlags = 4'h0;
  csr_pkg::csr_reg_req_t regReq = 16'h0000;
  logic wdtTimeout = 1'b0, pinResetWake = 1'b0, wakeEvent = 1'b0;
  logic useInstr = 1'b0, srcEn = 1'b0, rdPrev = 1'b0, slowPrev = 1'b0;
  logic [7:0] regRdData, statusOut, accRestore, a;
  csr_pkg::csr_ram_req_t ramReq;
  logic [11:0] fetchAddr, pcE;
  logic ctlPage, asleep, accRestoreValid, instrTick, slowClkPin;
  logic [1:0] regPage;
  logic [9:0] r;
  logic [31:0] rs = 32'h00001b4c;
  logic [6:0] ev[10] = '{7'h22, 7'h10, 7'h43, 7'h11, 7'h43, 7'h22, 7'h0a, 7'h22, 7'h06, 7'h43};
  csr_pkg::csr_op_t rets[2] = '{csr_pkg::OP_RET, csr_pkg::OP_RETURN_WITH_LITERAL};
  csr_note_t q[$];
  logic [7:0] rq[$];
  int failures = 0, cmp_count = 0, ticks = 0, cycles = 0;

  always #2 core_clk = ~core_clk;

  csr_core_regs #(.STACK_DEPTH(8)) i_dut (.core_clk(core_clk), .arst_n(arst_n), .op(op),
    .operand(operand), .acc(acc), .aluFlags(aluFlags), .regReq(regReq), .instrTick(instrTick),
    .slowClkPin(slowClkPin), .timerUseInstrClk(useInstr), .wdtTimeout(wdtTimeout),
    .pinResetWake(pinResetWake), .wakeEvent(wakeEvent), .regRdData(regRdData), .ramReq(ramReq),
    .fetchAddr(fetchAddr), .statusOut(statusOut), .ctlPage(ctlPage), .regPage(regPage),
    .asleep(asleep), .accRestore(accRestore), .accRestoreValid(accRestoreValid));
  csr_src_model i_src (.core_clk(core_clk), .arst_n(arst_n), .en(srcEn),
    .instrTick(instrTick), .slowClkPin(slowClkPin));

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd

  function automatic void note(logic [1:0] k, logic [11:0] v);
    q.push_back({k, v});
  endfunction : note

  task automatic results();
    if (failures == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  task automatic chk(string n, logic [11:0] e, logic [11:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk

  // All inputs but reset, the timer source select and the two count sources are set together once per falling edge
  task automatic drv(csr_pkg::csr_op_t o, logic [9:0] d = 10'h000, logic [7:0] x = 8'h00,
      logic [15:0] req = 16'h0000, logic [2:0] c = 3'h0, logic [3:0] f = 4'h0);
    op = o;
    operand = d;
    acc = x;
    regReq = req;
    {wdtTimeout, pinResetWake, wakeEvent} = c;
    aluFlags = f;
    @(negedge core_clk);
  endtask : drv

  task automatic wr(logic [5:0] ad, logic [7:0] v);
    drv(csr_pkg::OP_NONE, 10'h000, 8'h00, {2'b01, ad, v});
  endtask : wr

  task automatic rd(logic [5:0] ad, logic [7:0] e);
    rq.push_back(e);
    drv(csr_pkg::OP_NONE, 10'h000, 8'h00, {2'b10, ad, 8'h00});
  endtask : rd

  // Pre-edge values are the settled results of the last cycle
  always @(posedge core_clk) begin
    csr_note_t n;
    if (rdPrev) chk("regRdData", {4'h0, rq.pop_front()}, {4'h0, regRdData});
    while (q.size() > 0) begin
      n = q.pop_front();
      case (n.k)
        2'h0: chk("fetchAddr", n.v, fetchAddr);
        2'h1: chk("statusFlags", n.v, {6'h00, ctlPage, regPage, asleep, statusOut[4:3]});
        2'h2: chk("ramReq", n.v, {2'h0, ramReq});
        default: chk("accRestore", n.v, {3'h0, accRestoreValid, accRestore});
      endcase
    end
    rdPrev = regReq.rd;
    if (srcEn && (useInstr ? instrTick : slowClkPin && !slowPrev)) ticks++;
    slowPrev = slowClkPin;
    cycles++;
    if (cycles == 3000) begin
      failures++;
      results();
    end
  end

  initial begin
    repeat (20) @(negedge core_clk);
    arst_n = 1'b1;
    note(0, 12'h000);
    rd(6'h03, 8'h18);
    rd(6'h04, 8'h00);
    repeat (3) drv(csr_pkg::OP_NEXT);
    note(0, 12'h003);
    wr(6'h05, 8'hf2);
    rd(6'h05, 8'h02);
    drv(csr_pkg::OP_PAGE, 10'h001);
    rd(6'h05, 8'h01);
    r = 10'(rnd());
    drv(csr_pkg::OP_JMP, r);
    pcE = {2'b01, r};
    note(0, pcE);
    foreach (rets[i]) begin
      drv(csr_pkg::OP_CALL, ~r);
      note(0, {2'b01, ~r});
      drv(rets[i]);
      pcE = pcE + 12'h001;
      note(0, pcE);
    end
    a = 8'(rnd());
    drv(csr_pkg::OP_MOVPC, 10'h3ff, a);
    note(0, {4'h4, a});
    drv(csr_pkg::OP_JMP, 10'h3c0);
    drv(csr_pkg::OP_ADDPC, 10'h000, a);
    note(0, {4'h4, 8'hc0 + a});
    drv(csr_pkg::OP_JMP, 10'h3f0);
    drv(csr_pkg::OP_TBL, 10'h000, 8'h20);
    note(0, 12'h710);
    wr(6'h03, 8'h25);
    note(1, 12'h023);
    drv(csr_pkg::OP_INT, 10'h000, 8'h5a);
    note(0, 12'h008);
    rd(6'h05, 8'h00);
    wr(6'h03, 8'h00);
    wr(6'h05, 8'h02);
    drv(csr_pkg::OP_RETURN_FROM_INTERRUPT);
    note(3, 12'h15a);
    note(0, 12'h710);
    rd(6'h03, 8'h3d);
    rd(6'h05, 8'h01);
    drv(csr_pkg::OP_NONE, 10'h000, 8'h00, 16'h0000, 3'h0, 4'he);
    rd(6'h03, 8'h3e);
    wr(6'h03, 8'h07);
    rd(6'h03, 8'h1f);
    for (int b = 0; b < 4; b++) begin
      a = {2'(b), 6'(rnd()) | 6'h10};
      wr(6'h04, a);
      rd(6'h04, a);
      note(2, {3'h1, a[5], a});
      rd(6'h00, 8'h00);
      note(2, {4'h3, a[7:6], 6'h2a});
      rd(6'h2a, 8'h00);
      note(2, {4'h2, a[7:6], 6'h15});
      rd(6'h15, 8'h00);
    end
    wr(6'h02, 8'h77);
    note(0, 12'h710);
    rd(6'h0a, 8'h00);
    foreach (ev[i]) begin
      drv(ev[i][6:5] == 2'h1 ? csr_pkg::OP_SLEEP : ev[i][6:5] == 2'h2 ? csr_pkg::OP_WATCHDOG_CLEAR_INSTRUCTION
        : csr_pkg::OP_NONE, 10'h000, 8'h00, 16'h0000, ev[i][4:2]);
      note(1, {9'h000, ev[i][6:5] == 2'h1, ev[i][1:0]});
      if (ev[i][4:3] != 2'h0) note(0, 12'h000);
    end
    // Slow source first, then the instruction tick
    for (int m = 0; m < 2; m++) begin
      useInstr = m[0];
      wr(6'h01, 8'hf0);
      ticks = 0;
      srcEn = 1'b1;
      repeat (40) drv(csr_pkg::OP_NONE);
      srcEn = 1'b0;
      repeat (8) drv(csr_pkg::OP_NONE);
      rd(6'h01, 8'hf0 + 8'(ticks));
    end
    wr(6'h03, 8'hc0);
    note(1, 12'h01b);
    rd(6'h03, 8'hd8);
    repeat (2) drv(csr_pkg::OP_NONE);
    results();
  end
endmodule : csr_core_regs_bench

// file: testbench/csr_src_model.sv
// Model of the count sources: instruction tick and slow pin
`timescale 1ns/1ps
module csr_src_model (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic en,
  output logic instrTick,
  output logic slowClkPin
);
  logic [7:0] cnt_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= en ? cnt_q + 8'h01 : 8'h00;
    end
  end
  // Slow source shortened to 16 cycles; both stand still when idle
  assign instrTick = en && (cnt_q[1:0] == 2'h3);
  assign slowClkPin = en && cnt_q[3];
endmodule : csr_src_model
